// file: pkg/arc_pkg.sv
// constants and types for the converter result and compare control block
package arc_pkg;
  localparam int AW = 12;
  localparam int DW = 32;
  localparam int RES_W = 10;
  localparam int BYTE_W = 8;
  localparam int CH_W = 4;
  localparam int DIV_W = 8;
  localparam int DCNT_W = 10;
  localparam int PCNT_W = 5;
  localparam int IDX_W = AW - 2;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h093;
  localparam logic [IDX_W-1:0] IDX_DIV = 10'h094;
  localparam logic [IDX_W-1:0] IDX_RES_LO = 10'h096;
  localparam logic [IDX_W-1:0] IDX_RES_HI = 10'h097;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h098;
  localparam logic [IDX_W-1:0] IDX_MASK = 10'h099;

  // control and status register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CMP_BIT = 1;
  localparam int CTRL_ALIGN_BIT = 2;
  localparam int CTRL_PUMP_BIT = 3;
  localparam int CTRL_PWR_BIT = 4;
  localparam int CTRL_CH_LSB = 8;
  localparam int STAT_FLAG_BIT = 0;

  // reset values
  localparam logic [BYTE_W-1:0] RES_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [CH_W-1:0] CH_RST = 4'h0;

  // timing
  localparam logic [8:0] DIV_BASE = 9'h100;
  localparam logic [PCNT_W-1:0] CONV_PERIODS = 5'h1a;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } arc_state_e;
endpackage

// file: pkg/arc_core_if.sv
// carrier between the control core, its clock divider and its formatter
`timescale 1ns/1ps
interface arc_core_if;
  import arc_pkg::*;
  logic [DIV_W-1:0] divider;
  logic run;
  logic tick;
  logic [RES_W-1:0] result;
  logic align_right;
  logic [BYTE_W-1:0] pack_hi;
  logic [BYTE_W-1:0] pack_lo;
  logic [BYTE_W-1:0] reg_hi;
  logic [BYTE_W-1:0] reg_lo;
  logic [RES_W-1:0] threshold;
  modport div_m (input divider, input run, output tick);
  modport fmt_m (input result, input align_right, input reg_hi, input reg_lo,
                 output pack_hi, output pack_lo, output threshold);
endinterface

// file: verilog/arc_clk_div.sv
// converter clock enable divider
`timescale 1ns/1ps
module arc_clk_div (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset
  arc_core_if.div_m dv // divider setting, run and tick
);
  import arc_pkg::*;

  logic [DCNT_W-1:0] cnt_r;
  logic [DCNT_W-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [DCNT_W-1:0] last;

  always_comb begin
    // two system cycles per step of the 256 minus setting count
    last = {9'(DIV_BASE - {1'b0, dv.divider}), 1'b0} - 10'h001;
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!dv.run) begin
      cnt_nxt = '0;
    // at or past the end: a divider rewrite mid-run must not let the count wrap
    end else if (cnt_r >= last) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 10'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign dv.tick = tick_r;
endmodule

// file: verilog/arc_format.sv
// result packing into byte registers and threshold unpacking
`timescale 1ns/1ps
module arc_format (
  arc_core_if.fmt_m fm // result, alignment, byte registers
);
  import arc_pkg::*;

  always_comb begin
    if (fm.align_right) begin
      fm.pack_hi = {6'h00, fm.result[9:8]};
      fm.pack_lo = fm.result[7:0];
      fm.threshold = {fm.reg_hi[1:0], fm.reg_lo};
    end else begin
      fm.pack_hi = fm.result[9:2];
      fm.pack_lo = {fm.result[1:0], 6'h00};
      fm.threshold = {fm.reg_hi, fm.reg_lo[7:6]};
    end
  end
endmodule

// file: verilog/arc_ctrl.sv
// converter result and compare control with Avalon-MM register slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
module arc_ctrl (
  input wire logic ref_clk, // 200 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [arc_pkg::AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [arc_pkg::DW-1:0] avs_writedata, // write data
  output logic [arc_pkg::DW-1:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [arc_pkg::RES_W-1:0] afe_data, // converted value
  input wire logic afe_above, // input above threshold
  output logic afe_sample, // begin of a conversion period
  output logic afe_conv_tick, // converter clock enable
  output logic [arc_pkg::CH_W-1:0] afe_channel, // input channel select
  output logic afe_pump_on, // charge pump enable
  output logic afe_power_on, // converter power
  output logic afe_compare_on, // compare mode
  output logic [arc_pkg::RES_W-1:0] afe_threshold, // compare threshold
  output logic irq // level interrupt
);
  import arc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  arc_core_if ifc ();

  arc_state_e state_r;
  arc_state_e state_nxt;
  logic [PCNT_W-1:0] pcnt_r;
  logic [PCNT_W-1:0] pcnt_nxt;
  logic start_r;
  logic start_nxt;
  logic cmp_r;
  logic cmp_nxt;
  logic align_r;
  logic align_nxt;
  logic pump_r;
  logic pump_nxt;
  logic pwr_r;
  logic pwr_nxt;
  logic [CH_W-1:0] ch_r;
  logic [CH_W-1:0] ch_nxt;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic [BYTE_W-1:0] lo_r;
  logic [BYTE_W-1:0] lo_nxt;
  logic [BYTE_W-1:0] hi_r;
  logic [BYTE_W-1:0] hi_nxt;
  logic flag_r;
  logic flag_nxt;
  logic mask_r;
  logic mask_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [DW-1:0] rdata_r;
  logic [DW-1:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic sample_r;
  logic sample_nxt;
  logic [RES_W-1:0] thr_r;
  logic [RES_W-1:0] dat_s1_r;
  logic [RES_W-1:0] dat_s2_r;
  logic abv_s1_r;
  logic abv_s2_r;
  logic [IDX_W-1:0] idx;
  logic wr_go;
  logic period_end;
  logic set_flag;

  function automatic logic hit(input logic go, input logic [IDX_W-1:0] a,
                               input logic [IDX_W-1:0] b);
    hit = go && (a == b);
  endfunction

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  arc_clk_div u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .dv(ifc.div_m)
  );

  arc_format u_fmt (
    .fm(ifc.fmt_m)
  );

  assign ifc.divider = div_r;
  assign ifc.run = (state_r == ST_CONV);
  assign ifc.result = dat_s2_r;
  assign ifc.align_right = align_r;
  assign ifc.reg_hi = hi_r;
  assign ifc.reg_lo = lo_r;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // data bus is held steady by the front end around period end,
  // so a plain two-stage capture per bit is enough
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dat_s1_r <= '0;
      dat_s2_r <= '0;
      abv_s1_r <= 1'b0;
      abv_s2_r <= 1'b0;
    end else begin
      dat_s1_r <= afe_data;
      dat_s2_r <= dat_s1_r;
      abv_s1_r <= afe_above;
      abv_s2_r <= abv_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    idx = avs_address[AW-1:2];
    wr_go = avs_write && !wait_r;
    state_nxt = state_r;
    pcnt_nxt = pcnt_r;
    start_nxt = start_r;
    cmp_nxt = cmp_r;
    align_nxt = align_r;
    pump_nxt = pump_r;
    pwr_nxt = pwr_r;
    ch_nxt = ch_r;
    div_nxt = div_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    mask_nxt = mask_r;
    sample_nxt = 1'b0;
    set_flag = 1'b0;
    period_end = ifc.tick && (pcnt_r == CONV_PERIODS - 5'h01);

    // bus handshake: one stall cycle, then a single accept cycle
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = '0;
      unique case (idx)
        IDX_CTRL: begin
          rdata_nxt[CTRL_START_BIT] = start_r;
          rdata_nxt[CTRL_CMP_BIT] = cmp_r;
          rdata_nxt[CTRL_ALIGN_BIT] = align_r;
          rdata_nxt[CTRL_PUMP_BIT] = pump_r;
          rdata_nxt[CTRL_PWR_BIT] = pwr_r;
          rdata_nxt[CTRL_CH_LSB +: CH_W] = ch_r;
        end
        IDX_DIV: rdata_nxt[DIV_W-1:0] = div_r;
        IDX_RES_LO: rdata_nxt[BYTE_W-1:0] = lo_r;
        IDX_RES_HI: rdata_nxt[BYTE_W-1:0] = hi_r;
        IDX_STAT: rdata_nxt[STAT_FLAG_BIT] = flag_r;
        IDX_MASK: rdata_nxt[STAT_FLAG_BIT] = mask_r;
        default: rdata_nxt = '0;
      endcase
    end

    // conversion sequencer
    unique case (state_r)
      ST_IDLE: begin
        pcnt_nxt = '0;
        if (start_r) begin
          state_nxt = ST_CONV;
          sample_nxt = 1'b1;
        end
      end
      ST_CONV: begin
        if (!start_r) begin
          state_nxt = ST_IDLE;
          pcnt_nxt = '0;
        end else if (period_end) begin
          pcnt_nxt = '0;
          if (cmp_r) begin
            // stays running; start is never cleared here
            sample_nxt = 1'b1;
            set_flag = abv_s2_r;
          end else begin
            lo_nxt = ifc.pack_lo;
            hi_nxt = ifc.pack_hi;
            start_nxt = 1'b0;
            set_flag = 1'b1;
            state_nxt = ST_IDLE;
          end
        end else if (ifc.tick) begin
          pcnt_nxt = pcnt_r + 5'h01;
        end
      end
    endcase

    // software writes take effect on the accept edge, except align while start is set
    if (hit(wr_go, idx, IDX_CTRL)) begin
      start_nxt = avs_writedata[CTRL_START_BIT];
      cmp_nxt = avs_writedata[CTRL_CMP_BIT];
      pump_nxt = avs_writedata[CTRL_PUMP_BIT];
      pwr_nxt = avs_writedata[CTRL_PWR_BIT];
      ch_nxt = avs_writedata[CTRL_CH_LSB +: CH_W];
      if (!start_r) begin
        align_nxt = avs_writedata[CTRL_ALIGN_BIT];
      end
    end
    if (hit(wr_go, idx, IDX_DIV)) begin
      div_nxt = avs_writedata[DIV_W-1:0];
    end
    // threshold load; hardware update in the same cycle loses
    if (hit(wr_go, idx, IDX_RES_LO)) begin
      lo_nxt = avs_writedata[BYTE_W-1:0];
    end
    if (hit(wr_go, idx, IDX_RES_HI)) begin
      hi_nxt = avs_writedata[BYTE_W-1:0];
    end
    if (hit(wr_go, idx, IDX_MASK)) begin
      mask_nxt = avs_writedata[STAT_FLAG_BIT];
    end

    // write one clears, a same-cycle event still sets
    flag_nxt = flag_r;
    if (hit(wr_go, idx, IDX_STAT) && avs_writedata[STAT_FLAG_BIT]) begin
      flag_nxt = 1'b0;
    end
    if (set_flag) begin
      flag_nxt = 1'b1;
    end
    irq_nxt = flag_nxt && mask_nxt;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      pcnt_r <= '0;
      start_r <= 1'b0;
      cmp_r <= 1'b0;
      align_r <= 1'b0;
      pump_r <= 1'b0;
      pwr_r <= 1'b0;
      ch_r <= CH_RST;
      div_r <= DIV_RST;
      lo_r <= RES_RST;
      hi_r <= RES_RST;
      flag_r <= 1'b0;
      mask_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= '0;
      irq_r <= 1'b0;
      sample_r <= 1'b0;
      thr_r <= '0;
    end else begin
      state_r <= state_nxt;
      pcnt_r <= pcnt_nxt;
      start_r <= start_nxt;
      cmp_r <= cmp_nxt;
      align_r <= align_nxt;
      pump_r <= pump_nxt;
      pwr_r <= pwr_nxt;
      ch_r <= ch_nxt;
      div_r <= div_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      sample_r <= sample_nxt;
      thr_r <= ifc.threshold;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign afe_sample = sample_r;
  assign afe_conv_tick = ifc.tick;
  assign afe_channel = ch_r;
  assign afe_pump_on = pump_r;
  assign afe_power_on = pwr_r;
  assign afe_compare_on = cmp_r;
  assign afe_threshold = thr_r;
  assign irq = irq_r;
endmodule

// file: tb/arc_ctrl_props.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module arc_ctrl_props
  import arc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic [arc_pkg::AW-1:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [arc_pkg::DW-1:0] avs_writedata, // write data
  input wire logic [arc_pkg::DW-1:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic afe_sample, // period start
  input wire logic afe_conv_tick, // converter tick
  input wire logic [arc_pkg::CH_W-1:0] afe_channel, // channel
  input wire logic afe_power_on, // power
  input wire logic afe_compare_on, // compare mode
  input wire logic irq // interrupt
);
  logic acc_w, is_ctl, gv_r, gv_nxt, sv_r, sv_nxt;
  logic [7:0] div_r, div_nxt;
  logic [11:0] gap_r, gap_nxt, ctl_r, ctl_nxt;
  logic [5:0] tc_r, tc_nxt;
  assign acc_w = avs_write && !avs_waitrequest;
  assign is_ctl = avs_address[11:2] == IDX_CTRL;
  // a start write clears the gap and period trackers so idle gaps never count
  always_comb begin
    div_nxt = (acc_w && avs_address[11:2] == IDX_DIV) ? avs_writedata[7:0] : div_r;
    ctl_nxt = (acc_w && is_ctl) ? avs_writedata[11:0] : ctl_r;
    gap_nxt = afe_conv_tick ? 12'h001 : gap_r + 12'h001;
    gv_nxt = (afe_sample || (acc_w && is_ctl)) ? 1'b0 : (afe_conv_tick || gv_r);
    tc_nxt = afe_sample ? 6'h00 : tc_r + {5'h00, afe_conv_tick};
    sv_nxt = (acc_w && is_ctl) ? 1'b0 : (afe_sample ? afe_compare_on : sv_r);
    if (rst) begin
      {div_nxt, ctl_nxt, gap_nxt, gv_nxt, tc_nxt, sv_nxt} = '0;
    end
  end
  always_ff @(posedge ref_clk) begin
    {div_r, ctl_r, gap_r, gv_r, tc_r, sv_r} <= {div_nxt, ctl_nxt, gap_nxt, gv_nxt, tc_nxt, sv_nxt};
  end
  // ---
  // assertions
  // ---
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("accept lasted more than one cycle");
  unmap_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[11:2] == 10'h000
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  rd_pad_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:12] == 20'h0_0000)
    else $error("unused read bits not zero");
  tick_gap_a: assert property (afe_conv_tick && gv_r |->
    gap_r == {2'b00, 9'h100 - {1'b0, div_r}, 1'b0}) else $error("tick spacing wrong");
  conv_len_a: assert property (afe_sample && sv_r && afe_compare_on |-> tc_r == 6'h1a)
    else $error("period tick count wrong");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc_w) || $past(acc_w, 2))
    else $error("interrupt dropped without a write");
  irq_rise_a: assert property ($rose(irq) |-> $past(afe_conv_tick) || $past(afe_conv_tick, 2)
    || $past(afe_conv_tick, 3) || $past(acc_w) || $past(acc_w, 2)) else $error("stray interrupt");
  ctrl_out_a: assert property (acc_w && is_ctl |-> ##3 (afe_power_on == ctl_r[CTRL_PWR_BIT]
    && afe_compare_on == ctl_r[CTRL_CMP_BIT] && afe_channel == ctl_r[11:8]))
    else $error("control outputs do not follow write");
endmodule

// file: tb/arc_afe_model.sv
// behavioural front end: track and hold, conversion window, comparator
`timescale 1ns/1ps
module arc_afe_model
  import arc_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic [arc_pkg::RES_W-1:0] vin, // input level
  input wire logic afe_sample, // period start
  input wire logic afe_conv_tick, // converter tick
  input wire logic afe_power_on, // power
  input wire logic [arc_pkg::RES_W-1:0] afe_threshold, // compare level
  output logic [arc_pkg::RES_W-1:0] afe_data, // converted value
  output logic afe_above // comparator
);
  logic [RES_W-1:0] held;
  logic [4:0] n;
  logic tog, live;
  initial begin
    held = '0;
    n = 5'h1a;
    tog = 1'b0;
  end
  always @(posedge ref_clk) begin
    tog <= !tog;
    if (afe_sample) begin
      held <= vin;
      n <= 5'h00;
    end else if (afe_conv_tick && n != 5'h1a) begin
      n <= n + 5'h01;
    end
  end
  // outside the hold window the lines wander so a late capture shows up
  assign live = afe_power_on && n != 5'h1a;
  assign afe_data = live ? held : held ^ (tog ? 10'h3ff : 10'h2aa);
  assign afe_above = live ? (held > afe_threshold) : tog;
endmodule

// file: tb/arc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module arc_ctrl_tb;
  import arc_pkg::*;
  localparam logic [AW-1:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [AW-1:0] A_DIV = {IDX_DIV, 2'b00};
  localparam logic [AW-1:0] A_LO = {IDX_RES_LO, 2'b00};
  localparam logic [AW-1:0] A_HI = {IDX_RES_HI, 2'b00};
  localparam logic [AW-1:0] A_ST = {IDX_STAT, 2'b00};
  localparam logic [AW-1:0] A_MK = {IDX_MASK, 2'b00};
  localparam logic [DW-1:0] START = 32'h0000_0001;
  localparam logic [DW-1:0] CMP = 32'h0000_0002;
  localparam logic [DW-1:0] ALGN = 32'h0000_0004;
  localparam logic [DW-1:0] PWR = 32'h0000_0010;
  logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, afe_above, afe_sample;
  logic afe_conv_tick, afe_pump_on, afe_power_on, afe_compare_on, irq;
  logic [AW-1:0] avs_address;
  logic [DW-1:0] avs_writedata, avs_readdata, rdata;
  logic [RES_W-1:0] afe_data, afe_threshold, vin;
  logic [CH_W-1:0] afe_channel;
  int fails, checks_done;
  arc_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .afe_data(afe_data), .afe_above(afe_above),
    .afe_sample(afe_sample), .afe_conv_tick(afe_conv_tick), .afe_channel(afe_channel),
    .afe_pump_on(afe_pump_on), .afe_power_on(afe_power_on), .afe_compare_on(afe_compare_on),
    .afe_threshold(afe_threshold), .irq(irq));
  arc_afe_model afe_u (.ref_clk(ref_clk), .vin(vin), .afe_sample(afe_sample),
    .afe_conv_tick(afe_conv_tick), .afe_power_on(afe_power_on),
    .afe_threshold(afe_threshold), .afe_data(afe_data), .afe_above(afe_above));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = !ref_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // held until the accepting edge; the extra edge keeps strobes from a double drive
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
  endtask
  task automatic cki(input logic exp);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, irq}, 32'h0000_0001);
  endtask
  task automatic conv(input logic [9:0] v, input logic [DW-1:0] c, input logic mid);
    vin <= v;
    wr(A_CTRL, c | START);
    if (mid) wr(A_CTRL, (c ^ ALGN) | START);
    wirq();
    rd(A_CTRL, c);
    if (c[CTRL_ALIGN_BIT]) begin
      rd(A_HI, {30'h0, v[9:8]});
      rd(A_LO, {24'h0, v[7:0]});
    end else begin
      rd(A_HI, {24'h0, v[9:2]});
      rd(A_LO, {24'h0, v[1:0], 6'h00});
    end
    wr(A_ST, 32'h0000_0001);
    rd(A_ST, 32'h0000_0000);
    $display("test conversion done");
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    final_report();
  end
  // ---
  // tests
  // ---
  initial begin
    {avs_read, avs_write, rst} = 3'b001;
    avs_address = '0;
    avs_writedata = '0;
    vin = '0;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(A_LO, 32'h0000_0000);
    rd(A_HI, 32'h0000_0000);
    wr(12'h000, 32'hffff_ffff);
    rd(12'h000, 32'h0000_0000);
    wr(A_DIV, 32'h0000_00ff);
    wr(A_MK, 32'h0000_0001);
    rd(A_DIV, 32'h0000_00ff);
    rd(A_MK, 32'h0000_0001);
    // pump is switched off again before any start, so no settling wait is owed
    wr(A_CTRL, 32'h0000_0008);
    chk({31'h0, afe_pump_on}, 32'h0000_0001);
    rd(A_CTRL, 32'h0000_0008);
    wr(A_CTRL, 32'h0000_0000);
    chk({31'h0, afe_pump_on}, 32'h0000_0000);
    $display("test reset and map done");
    // pump stays off, so no settling wait is owed before starting
    conv(10'h2b5, PWR | 32'h0000_0300, 1'b0);
    conv(10'h1c7, PWR | ALGN | 32'h0000_0500, 1'b0);
    wr(A_DIV, 32'h0000_00fc);
    conv(10'h36a, PWR | ALGN, 1'b1);
    vin <= 10'h0f0;
    wr(A_CTRL, PWR | START);
    wr(A_CTRL, PWR);
    repeat (300) @(posedge ref_clk);
    rd(A_ST, 32'h0000_0000);
    rd(A_LO, 32'h0000_006a);
    $display("test abort done");
    wr(A_DIV, 32'h0000_00ff);
    wr(A_MK, 32'h0000_0000);
    wr(A_HI, 32'h0000_0080);
    wr(A_LO, 32'h0000_0040);
    vin <= 10'h201;
    wr(A_CTRL, PWR | CMP | START);
    repeat (170) @(posedge ref_clk);
    rd(A_ST, 32'h0000_0000);
    rd(A_HI, 32'h0000_0080);
    vin <= 10'h202;
    repeat (130) @(posedge ref_clk);
    rd(A_ST, 32'h0000_0001);
    cki(1'b0);
    wr(A_MK, 32'h0000_0001);
    cki(1'b1);
    wr(A_ST, 32'h0000_0001);
    wirq();
    rd(A_CTRL, PWR | CMP | START);
    wr(A_CTRL, PWR | CMP);
    wr(A_ST, 32'h0000_0001);
    repeat (170) @(posedge ref_clk);
    rd(A_ST, 32'h0000_0000);
    rd(A_LO, 32'h0000_0040);
    $display("test compare done");
    // second reset with loaded bytes: both must come back as zero
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(A_LO, 32'h0000_0000);
    rd(A_HI, 32'h0000_0000);
    rd(A_CTRL, 32'h0000_0000);
    $display("test second reset done");
    final_report();
  end
endmodule
bind arc_ctrl arc_ctrl_props props_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .afe_sample(afe_sample),
  .afe_conv_tick(afe_conv_tick), .afe_channel(afe_channel), .afe_power_on(afe_power_on),
  .afe_compare_on(afe_compare_on), .irq(irq));
